/* File: shared/ssl_pkg.sv */
// shared constants for the synthesizer serial load link
package ssl_pkg;
    // serial word
    localparam int WORD_BITS = 24;
    localparam int CNT_RESET_POS = 2;
    // latch select codes, low two bits of a word
    localparam logic [1:0] SEL_REF = 2'h0;
    localparam logic [1:0] SEL_AB = 2'h1;
    localparam logic [1:0] SEL_FUNC = 2'h2;
    localparam logic [1:0] SEL_INIT = 2'h3;
    // timing
    localparam int CLK_MHZ = 200;
    localparam int SCLK_MAX_MHZ = 20;
    localparam int SCLK_HALF_CYC =
        (CLK_MHZ + 2 * SCLK_MAX_MHZ - 1) / (2 * SCLK_MAX_MHZ);
    localparam int STROBE_CYC = 8;
    localparam int SETTLE_NS = 1;
    localparam int SETTLE_CYC = (SETTLE_NS * 1000 * CLK_MHZ + 999) / 1000;
    // host register map
    localparam int AXI_ADDR_W = 4;
    localparam logic [3:0] ADDR_WORD = 4'h0;
    localparam logic [3:0] ADDR_CTRL = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    localparam int CTRL_PE_POS = 0;
    localparam logic CTRL_PE_RESET = 1'h0;
    localparam int STAT_BUSY_POS = 0;
    localparam int STAT_SETTLED_POS = 1;
    localparam int STAT_PE_POS = 2;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

/* File: shared/ssl_if.sv */
// three-wire serial link plus power enable pin between host and synthesizer
`timescale 1ns/100ps
interface ssl_if;
    logic sclk;          // serial clock, data taken on its rise
    logic sdata;         // serial data, msb first
    logic latch_strobe;  // rise moves the shifted word into a latch
    logic power_enable;  // low powers the device down
    modport host (
        output sclk,
        output sdata,
        output latch_strobe,
        output power_enable
    );
    modport device (
        input sclk,
        input sdata,
        input latch_strobe,
        input power_enable
    );
endinterface

/* File: src/ssl_device.sv */
// synthesizer end: serial input register, four latches, start-up control
// Function
// - code 11 selects initialization latch
// - code 10 selects function latch
// - code 00 selects reference counter latch
// - code 01 selects AB counter latch
// - initialization load also fills function latch
// - initialization load fires internal counter reset pulse
// - first AB load afterwards pulses again
// - enable pin low powers down at once
// - enable high again resumes aligned counting
// - host waits about 1 us settling
// - latches survive enable pin cycling
// - counter reset bit holds counters, no power-down
// - counter reset start-up write order
// - initialization start-up write order, reset bit 0
// - pin start-up: writes while enable low
// - shift one bit per serial clock rise
// - strobe rise transfers word to selected latch
// - serial clock at most 20 MHz
// - strobe low during three bytes, then high
// - four writes after power-up before output active; the code waits for all four latches, and an initialization write fills two
// - counter reset bit sits at bit 2
`timescale 1ns/100ps
module ssl_device (
    // clock and reset
    input logic aclk,
    input logic aresetn,
    // serial link from the host
    ssl_if.device bus,
    // latch contents
    output logic [23:0] init_latch,
    output logic [23:0] function_latch,
    output logic [23:0] ref_latch,
    output logic [23:0] ab_latch,
    // counter control towards the divider core
    output logic internal_reset,
    output logic counters_held,
    output logic cp_tristate,
    output logic power_down,
    output logic counters_run,
    output logic programmed
);

    // whole state of the device end
    typedef struct packed {
        // synchroniser stages, s1 is read only by s2
        logic sclk_s1;
        logic sclk_s2;
        logic sclk_s3;   // previous s2, for edge finding
        logic data_s1;
        logic data_s2;
        logic le_s1;
        logic le_s2;
        logic le_s3;
        logic pe_s1;
        logic pe_s2;
        // input shift register
        logic [ssl_pkg::WORD_BITS-1:0] shift;
        // latches, indexed by select code
        logic [3:0][ssl_pkg::WORD_BITS-1:0] latch;
        // which latches were written since reset
        logic [3:0] loaded;
        // next AB load fires the pulse again
        logic ab_armed;
        // outputs
        logic rst_pulse;
        logic held;
        logic tristate;
        logic pdown;
        logic run;
        logic prog;
    } ssl_dev_state_type;

    ssl_dev_state_type q;  // registered state
    ssl_dev_state_type d;  // next state

    logic sclk_rise;  // serial clock rose
    logic le_rise;    // strobe rose
    logic [1:0] sel;  // select code of the shifted word

    // edge finding on the settled synchroniser outputs only
    // 200 MHz sampling leaves five samples per half of a 20 MHz clock
    assign sclk_rise = q.sclk_s2 && !q.sclk_s3;
    assign le_rise = q.le_s2 && !q.le_s3;
    assign sel = q.shift[1:0];

    // next-state logic
    always_comb begin
        d = q;
        // two-flop synchronisers on every pin
        d.sclk_s1 = bus.sclk;
        d.sclk_s2 = q.sclk_s1;
        d.sclk_s3 = q.sclk_s2;
        d.data_s1 = bus.sdata;
        d.data_s2 = q.data_s1;
        d.le_s1 = bus.latch_strobe;
        d.le_s2 = q.le_s1;
        d.le_s3 = q.le_s2;
        d.pe_s1 = bus.power_enable;
        d.pe_s2 = q.pe_s1;
        // the pulse lasts one clock unless fired again
        d.rst_pulse = 1'b0;

        // shift msb first; oldest bits fall off the top
        // data and clock pass equal synchroniser depth, so the sample
        // still sits inside the host's data-valid window
        if (sclk_rise) begin
            d.shift = {q.shift[ssl_pkg::WORD_BITS-2:0],
                q.data_s2};
        end

        // the shift register keeps loading while powered down, so the
        // pin start-up can program latches with the enable pin low
        if (le_rise) begin
            // select code doubles as latch index
            d.latch[sel] = q.shift;
            d.loaded[sel] = 1'b1;
            unique case (sel)
                ssl_pkg::SEL_INIT: begin
                    // initialization word: contents go to function latch too
                    d.latch[ssl_pkg::SEL_FUNC] = q.shift;
                    d.loaded[ssl_pkg::SEL_FUNC] = 1'b1;
                    // reset pulse now and once more at the next AB load
                    d.rst_pulse = 1'b1;
                    d.ab_armed = 1'b1;
                end
                ssl_pkg::SEL_FUNC: begin
                    // function word, stored above
                    d.loaded[ssl_pkg::SEL_FUNC] = 1'b1;
                end
                ssl_pkg::SEL_REF: begin
                    // reference counter word, stored above
                    d.loaded[ssl_pkg::SEL_REF] = 1'b1;
                end
                ssl_pkg::SEL_AB: begin
                    // only the first AB load after an initialization pulses
                    d.loaded[ssl_pkg::SEL_AB] = 1'b1;
                    if (q.ab_armed) begin
                        d.rst_pulse = 1'b1;
                        d.ab_armed = 1'b0;
                    end
                end
            endcase
        end

        // pin power-down is not gated by any charge pump event;
        // the only delay is the synchroniser
        d.pdown = !q.pe_s2;

        // latches are never cleared by the pin, only by aresetn
        // counters held by pulse, reset bit or power-down
        d.held = d.rst_pulse || d.pdown
            || d.latch[ssl_pkg::SEL_FUNC][ssl_pkg::CNT_RESET_POS];
        // charge pump tri-stated whenever the counters are held
        d.tristate = d.held;
        // all four latches written since reset
        d.prog = &d.loaded;
        // counting restarts from load point in the same clock for both
        // counters, which keeps them in phase
        d.run = !d.held && d.prog;
    end

    // state register; synchronous active-low reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            // powered down until the pin has been seen high
            q.pdown <= 1'b1;
            q.held <= 1'b1;
            q.tristate <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state register
    assign init_latch = q.latch[ssl_pkg::SEL_INIT];
    assign function_latch = q.latch[ssl_pkg::SEL_FUNC];
    assign ref_latch = q.latch[ssl_pkg::SEL_REF];
    assign ab_latch = q.latch[ssl_pkg::SEL_AB];
    assign internal_reset = q.rst_pulse;
    assign counters_held = q.held;
    assign cp_tristate = q.tristate;
    assign power_down = q.pdown;
    assign counters_run = q.run;
    assign programmed = q.prog;

endmodule

/* File: src/ssl_host.sv */
// host end: axi4-lite registers driving the three-wire serial writes
//
// The AXI4-Lite slave port and the address map were decided locally.
`timescale 1ns/100ps
module ssl_host (
    // clock and reset
    input logic aclk,
    input logic aresetn,
    // axi4-lite write address
    input logic awvalid,
    output logic awready,
    input logic [3:0] awaddr,
    // axi4-lite write data
    input logic wvalid,
    output logic wready,
    input logic [31:0] wdata,
    input logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input logic arvalid,
    output logic arready,
    input logic [3:0] araddr,
    // axi4-lite read data
    output logic rvalid,
    input logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // serial link to the device
    ssl_if.host bus
);

    // serial sequencer states
    typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_STROBE}
        ssl_host_st_type;

    // whole state of the host end
    typedef struct packed {
        logic aw_rdy;
        logic w_rdy;
        logic [3:0] waddr;
        logic [31:0] wd;
        logic [3:0] ws;
        logic bv;
        logic [1:0] br;
        logic ar_rdy;
        logic rv;
        logic [31:0] rd;
        logic [1:0] rr;
        ssl_host_st_type st;
        logic [23:0] tx;
        logic [4:0] bits;
        logic [7:0] tick;
        logic sclk;
        logic sdata;
        logic strobe;
        logic pe;
        logic [7:0] settle;
        logic settled;
    } ssl_host_state_type;

    ssl_host_state_type q;
    ssl_host_state_type d;

    logic half_done;  // divider enable: half a serial clock elapsed

    assign half_done = q.tick == 8'(ssl_pkg::SCLK_HALF_CYC - 1);

    // next-state logic
    always_comb begin
        d = q;
        // take address and data in either order
        if (awvalid && q.aw_rdy) begin
            d.aw_rdy = 1'b0;
            d.waddr = awaddr;
        end
        if (wvalid && q.w_rdy) begin
            d.w_rdy = 1'b0;
            d.wd = wdata;
            d.ws = wstrb;
        end
        // both held: perform the write and answer
        if (!q.aw_rdy && !q.w_rdy && !q.bv) begin
            d.bv = 1'b1;
            d.br = ssl_pkg::RESP_OKAY;
            case (q.waddr)
                ssl_pkg::ADDR_WORD: begin
                    // a word written while sending is refused, never queued
                    if (q.st != ST_IDLE) begin
                        d.br = ssl_pkg::RESP_SLVERR;
                    end else begin
                        d.tx = q.wd[23:0];
                        d.bits = 5'(ssl_pkg::WORD_BITS);
                        d.tick = 8'h00;
                        d.st = ST_LOW;
                    end
                end
                ssl_pkg::ADDR_CTRL: begin
                    // software orders the start-up sequence through these
                    if (q.ws[0]) begin
                        d.pe = q.wd[ssl_pkg::CTRL_PE_POS];
                    end
                end
                ssl_pkg::ADDR_STATUS: d.br = ssl_pkg::RESP_SLVERR;
                default: d.br = ssl_pkg::RESP_DECERR;
            endcase
        end
        // response taken: accept the next write
        if (q.bv && bready) begin
            d.bv = 1'b0;
            d.aw_rdy = 1'b1;
            d.w_rdy = 1'b1;
        end
        // read channel, one at a time
        if (arvalid && q.ar_rdy) begin
            d.ar_rdy = 1'b0;
            d.rv = 1'b1;
            d.rd = 32'h00000000;
            d.rr = ssl_pkg::RESP_OKAY;
            case (araddr)
                ssl_pkg::ADDR_WORD: d.rd = {8'h00, q.tx};
                ssl_pkg::ADDR_CTRL: d.rd[ssl_pkg::CTRL_PE_POS] = q.pe;
                ssl_pkg::ADDR_STATUS: begin
                    d.rd[ssl_pkg::STAT_BUSY_POS] = q.st != ST_IDLE;
                    d.rd[ssl_pkg::STAT_SETTLED_POS] = q.settled;
                    d.rd[ssl_pkg::STAT_PE_POS] = q.pe;
                end
                default: d.rr = ssl_pkg::RESP_DECERR;
            endcase
        end
        if (q.rv && rready) begin
            d.rv = 1'b0;
            d.ar_rdy = 1'b1;
        end

        // serial sequencer; strobe stays low through all 24 bits
        unique case (q.st)
            ST_IDLE: d.tick = 8'h00;
            ST_LOW: begin
                if (half_done) begin
                    d.tick = 8'h00;
                    d.sclk = 1'b1;
                    d.st = ST_HIGH;
                end else begin
                    d.tick = q.tick + 8'h01;
                end
            end
            ST_HIGH: begin
                if (half_done) begin
                    d.tick = 8'h00;
                    d.sclk = 1'b0;
                    d.tx = {q.tx[22:0], 1'b0};
                    d.bits = q.bits - 5'h01;
                    d.st = (q.bits == 5'h01) ? ST_STROBE : ST_LOW;
                    d.strobe = q.bits == 5'h01;
                end else begin
                    d.tick = q.tick + 8'h01;
                end
            end
            ST_STROBE: begin
                // long enough for the device synchroniser to see it
                if (q.tick == 8'(ssl_pkg::STROBE_CYC - 1)) begin
                    d.strobe = 1'b0;
                    d.st = ST_IDLE;
                end else begin
                    d.tick = q.tick + 8'h01;
                end
            end
        endcase
        // msb first; data only moves while the clock is low
        d.sdata = d.tx[23];

        // settling timer after the enable pin rises
        if (!q.pe) begin
            d.settle = 8'h00;
            d.settled = 1'b0;
        end else if (!q.settled) begin
            if (q.settle == 8'(ssl_pkg::SETTLE_CYC - 1)) begin
                d.settled = 1'b1;
            end else begin
                d.settle = q.settle + 8'h01;
            end
        end
    end

    // state register; synchronous active-low reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.aw_rdy <= 1'b1;
            q.w_rdy <= 1'b1;
            q.ar_rdy <= 1'b1;
            q.pe <= ssl_pkg::CTRL_PE_RESET;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state register
    assign awready = q.aw_rdy;
    assign wready = q.w_rdy;
    assign bvalid = q.bv;
    assign bresp = q.br;
    assign arready = q.ar_rdy;
    assign rvalid = q.rv;
    assign rdata = q.rd;
    assign rresp = q.rr;
    assign bus.sclk = q.sclk;
    assign bus.sdata = q.sdata;
    assign bus.latch_strobe = q.strobe;
    assign bus.power_enable = q.pe;

endmodule

/* File: sim/ssl_monitor.sv */
// link protocol checker for the synthesizer serial link
`timescale 1ns/100ps
module ssl_monitor (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // link wires
    input wire logic sclk,
    input wire logic sdata,
    input wire logic latch_strobe,
    input wire logic power_enable
);
    logic [5:0] bits_q; // serial clock rises since last strobe
    logic [5:0] bits_d;
    logic sclk_q; // last serial clock, for edge finding
    // count the bits of the frame under way
    always_comb begin
        bits_d = bits_q;
        if (latch_strobe) begin
            bits_d = 6'h00;
        end else if (sclk && !sclk_q) begin
            bits_d = bits_q + 6'h01;
        end
    end
    // helper registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bits_q <= 6'h00;
            sclk_q <= 1'h0;
        end else begin
            bits_q <= bits_d;
            sclk_q <= sclk;
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // high half never shorter than 25 ns
    sclk_high_a: assert property (
        $rose(sclk) |=> sclk [*4])
        else $error("serial clock high phase too short");
    sclk_low_a: assert property (
        $rose(sclk) |-> !$past(sclk, 5))
        else $error("serial clock low phase too short");
    data_hold_a: assert property (
        $rose(sclk) |=> $stable(sdata) [*4])
        else $error("serial data moved while clock high");
    strobe_idle_a: assert property (
        latch_strobe |-> !sclk)
        else $error("serial clock ran during strobe");
    strobe_width_a: assert property (
        $rose(latch_strobe) |-> latch_strobe [*8] ##1 !latch_strobe)
        else $error("strobe width wrong");
    frame_bits_a: assert property (
        $rose(latch_strobe) |-> bits_q == 6'h18)
        else $error("frame did not hold 24 bits");
    strobe_last_a: assert property (
        $rose(latch_strobe) |-> $fell(sclk))
        else $error("strobe not right after last bit");
    bits_max_a: assert property (
        !latch_strobe |-> bits_q <= 6'h18)
        else $error("more than 24 bits in a frame");
    // main scenarios reached
    cover property ($rose(latch_strobe));
    cover property ($fell(power_enable));
    cover property ($rose(power_enable));
endmodule

/* File: sim/test_synth_serial_load_and_init.sv */
// bench: host and device ends joined over the serial link
`timescale 1ns/100ps
module test_synth_serial_load_and_init;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    wire [23:0] lat [4]; // latches indexed by select code
    logic [23:0] seen [4]; // latch values at the last edge
    logic irst, held, cpt, pdn, run, prog;
    logic [27:0] notes [$]; // expected results: kind, value
    logic armed; // next ab load should pulse
    int bad_count, cmp_count;
    ssl_if link ();
    ssl_host ssl_host_i (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
        .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .bus(link));
    ssl_device ssl_device_i (.aclk(aclk), .aresetn(aresetn), .bus(link),
        .init_latch(lat[3]), .function_latch(lat[2]), .ref_latch(lat[0]),
        .ab_latch(lat[1]), .internal_reset(irst), .counters_held(held),
        .cp_tristate(cpt), .power_down(pdn), .counters_run(run),
        .programmed(prog));
    ssl_monitor ssl_monitor_i (.aclk(aclk), .aresetn(aresetn),
        .sclk(link.sclk), .sdata(link.sdata),
        .latch_strobe(link.latch_strobe), .power_enable(link.power_enable));
    // 200 MHz clock
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_lat(input logic [27:0] got, input logic [27:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // oldest note against what appeared; an empty queue is a mismatch
    task automatic take(input logic [27:0] got);
        if (notes.size() == 0) begin
            chk_lat(got, 28'hFFFFFFF);
        end else begin
            chk_lat(got, notes.pop_front());
        end
    endtask
    // result watcher: latch changes then reset pulses
    always @(posedge aclk) begin
        if (!aresetn) begin
            seen = '{default: 24'h000000};
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (lat[i] !== seen[i]) take({i[3:0], lat[i]});
                seen[i] = lat[i];
            end
            if (irst === 1'b1) take({4'h4, 24'h000000});
        end
    end
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
        input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        chk_bus({30'h0, bresp}, {30'h0, er});
    endtask
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
        output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
    endtask
    // poll status until the frame is out, then let the device catch up
    task automatic idle();
        logic [31:0] s;
        logic [1:0] r;
        do axi_rd(ssl_pkg::ADDR_STATUS, s, r);
        while (s[ssl_pkg::STAT_BUSY_POS]);
        repeat (8) @(posedge aclk);
    endtask
    // one word to one latch, or to two for an initialization word, noting every expected result
    task automatic send(input logic [1:0] c, input logic b);
        logic [23:0] w;
        w = {22'($urandom() << 1) | 22'(b), c};
        axi_wr(ssl_pkg::ADDR_WORD, {8'h00, w}, ssl_pkg::RESP_OKAY);
        if (c == ssl_pkg::SEL_INIT) notes.push_back({4'h2, w});
        notes.push_back({2'h0, c, w});
        if (c == ssl_pkg::SEL_INIT || (c == ssl_pkg::SEL_AB && armed))
            notes.push_back({4'h4, 24'h000000});
        if (c == ssl_pkg::SEL_AB) armed = 1'b0;
        if (c == ssl_pkg::SEL_INIT) armed = 1'b1;
        idle();
    endtask
    // levels: held, tristate, power-down, run, programmed
    task automatic lvl(input logic [4:0] e);
        chk_bus({27'h0, held, cpt, pdn, run, prog}, {27'h0, e});
    endtask
    // watchdog, well beyond the expected run
    initial begin
        #300000;
        bad_count++;
        stop_test();
    end
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        {aresetn, awvalid, wvalid, arvalid, armed} = 5'h00;
        {bready, rready, awaddr, araddr, wdata, wstrb} = {2'h3, 40'h0, 4'hF};
        bad_count = 0;
        cmp_count = 0;
        void'($urandom(32'hBA42));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        lvl(5'h1C);
        // initialization method, then a second ab load without pulse
        axi_wr(ssl_pkg::ADDR_CTRL, 32'h1, ssl_pkg::RESP_OKAY);
        send(ssl_pkg::SEL_INIT, 1'b0);
        send(ssl_pkg::SEL_FUNC, 1'b0);
        send(ssl_pkg::SEL_REF, 1'($urandom()));
        send(ssl_pkg::SEL_AB, 1'($urandom()));
        send(ssl_pkg::SEL_AB, 1'($urandom()));
        lvl(5'h03);
        $display("init method done");
        // counter reset method
        send(ssl_pkg::SEL_FUNC, 1'b1);
        lvl(5'h19);
        send(ssl_pkg::SEL_REF, 1'($urandom()));
        send(ssl_pkg::SEL_AB, 1'($urandom()));
        send(ssl_pkg::SEL_FUNC, 1'b0);
        lvl(5'h03);
        $display("counter reset method done");
        // enable pin method, then cycling keeps the latches
        axi_wr(ssl_pkg::ADDR_CTRL, 32'h0, ssl_pkg::RESP_OKAY);
        repeat (6) @(posedge aclk);
        lvl(5'h1D);
        send(ssl_pkg::SEL_FUNC, 1'b0);
        send(ssl_pkg::SEL_REF, 1'($urandom()));
        send(ssl_pkg::SEL_AB, 1'($urandom()));
        axi_wr(ssl_pkg::ADDR_CTRL, 32'h1, ssl_pkg::RESP_OKAY);
        axi_rd(ssl_pkg::ADDR_STATUS, d, r);
        chk_bus(d, 32'h4);
        repeat (6) @(posedge aclk);
        lvl(5'h03);
        repeat (200) @(posedge aclk);
        axi_rd(ssl_pkg::ADDR_STATUS, d, r);
        chk_bus(d, 32'h6);
        axi_wr(ssl_pkg::ADDR_CTRL, 32'h0, ssl_pkg::RESP_OKAY);
        axi_wr(ssl_pkg::ADDR_CTRL, 32'h1, ssl_pkg::RESP_OKAY);
        repeat (6) @(posedge aclk);
        lvl(5'h03);
        $display("pin method done");
        // refusals: word while busy, read-only and unmapped places
        // low bits 00: reference latch only, no pulse
        axi_wr(ssl_pkg::ADDR_WORD, 32'h00A5C0, ssl_pkg::RESP_OKAY);
        notes.push_back({4'h0, 24'h00A5C0});
        axi_wr(ssl_pkg::ADDR_WORD, 32'h1, ssl_pkg::RESP_SLVERR);
        idle();
        axi_wr(ssl_pkg::ADDR_STATUS, 32'h0, ssl_pkg::RESP_SLVERR);
        axi_wr(4'hC, 32'h0, ssl_pkg::RESP_DECERR);
        axi_rd(4'hC, d, r);
        chk_bus({d[29:0], r}, {30'h0, ssl_pkg::RESP_DECERR});
        // control write with no byte enabled leaves the pin high
        wstrb <= 4'h0;
        axi_wr(ssl_pkg::ADDR_CTRL, 32'h0, ssl_pkg::RESP_OKAY);
        wstrb <= 4'hF;
        axi_rd(ssl_pkg::ADDR_CTRL, d, r);
        chk_bus(d, 32'h1);
        $display("refusals done");
        chk_bus(notes.size(), 32'h0);
        stop_test();
    end
endmodule
